// ==== include/pipe_ready_pkg.sv ====
package pipe_ready_pkg;
   // Pipe count and index of the default control pipe
   localparam int NUM_PIPES = 10;
   localparam int CTRL_PIPE_IDX = 0;
   // Reset values of status state
   localparam logic FLAG_RESET = 1'h0;
   localparam logic SUMMARY_RESET = 1'h0;
   // Mode codes formed from {status_linking_select, read_complete_select}
   localparam logic [1:0] MODE_PORT = 2'h0;
   localparam logic [1:0] MODE_READ_DONE = 2'h1;
   localparam logic [1:0] MODE_LINKED = 2'h2;
   // Width of the per-pipe transfer-end tracker
   localparam int END_STATE_W = 2;
endpackage : pipe_ready_pkg

// ==== design/pipe_ready_trigger.sv ====
`timescale 1ns/1ps
`default_nettype none
// Port-accessible trigger detection for one pipe
module pipe_ready_trigger
(
   input wire logic clock_i,
   input wire logic reset_n_i,
   input wire logic is_ctrl_pipe_i,
   input wire logic dir_tx_i,
   input wire logic func_mode_i,
   input wire logic status_stage_i,
   input wire logic buf_ready_i,
   input wire logic tx_done_i,
   input wire logic rx_done_i,
   input wire logic rx_toggle_bad_i,
   input wire logic cpu_side_done_i,
   input wire logic other_buf_ok_i,
   input wire logic auto_clear_wr_i,
   output logic trigger_o
);
   logic dir_q;
   logic trig;

   // Direction history for the receive-to-transmit edge
   always_ff @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         dir_q <= 1'h0;
      else
         dir_q <= dir_tx_i;
   end

   // Transmit and receive trigger sources
   always_comb
   begin
      trig = 1'b0;
      if (dir_tx_i)
      begin
         if (!dir_q)
            trig = 1'b1;
         if (tx_done_i && !buf_ready_i)
            trig = 1'b1;
         // A swap only counts once the CPU is done with its own buffer
         if (cpu_side_done_i && other_buf_ok_i)
            trig = 1'b1;
         if (auto_clear_wr_i && !buf_ready_i)
            trig = 1'b1;
         if (is_ctrl_pipe_i)
            trig = 1'b0;
      end
      else
      begin
         if (rx_done_i && !rx_toggle_bad_i && !buf_ready_i)
            trig = 1'b1;
         if (cpu_side_done_i && other_buf_ok_i)
            trig = 1'b1;
      end
      if (func_mode_i && status_stage_i)
         trig = 1'b0;
   end

   assign trigger_o = trig;

   a_ctrl_tx_quiet: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (is_ctrl_pipe_i && dir_tx_i) |-> !trigger_o)
      else $error("control pipe transmit trigger raised");
   a_toggle_bad_quiet: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (!dir_tx_i && rx_done_i && rx_toggle_bad_i && !cpu_side_done_i) |-> !trigger_o)
      else $error("trigger on toggle mismatch");
   a_status_quiet: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (func_mode_i && status_stage_i) |-> !trigger_o)
      else $error("trigger in status stage");
endmodule : pipe_ready_trigger
`default_nettype wire

// ==== design/pipe_read_complete.sv ====
`timescale 1ns/1ps
`default_nettype none
// Tracks end of transfer and full read-out for one receive pipe
module pipe_read_complete
(
   input wire logic clock_i,
   input wire logic reset_n_i,
   input wire logic enable_i,
   input wire logic rx_short_i,
   input wire logic rx_count_end_i,
   input wire logic rx_zlp_empty_i,
   input wire logic read_out_i,
   input wire logic clear_i,
   output logic done_o
);
   typedef enum logic [pipe_ready_pkg::END_STATE_W-1:0] {
      ST_IDLE = 2'h0,
      ST_ENDED = 2'h1,
      ST_HOLD = 2'h2
   } end_state_e;
   end_state_e state_q;

   // Transfer ends on short packet or counter reached; ZLP into empty done at once
   always_ff @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         state_q <= ST_IDLE;
      else if (clear_i || !enable_i)
         state_q <= ST_IDLE;
      else
      begin
         unique case (state_q)
            ST_IDLE:
               if (rx_zlp_empty_i)
                  state_q <= ST_HOLD;
               else if (rx_short_i || rx_count_end_i)
                  state_q <= ST_ENDED;
            ST_ENDED:
               if (read_out_i)
                  state_q <= ST_IDLE;
            // Stays parked until the buffer is cleared for the next transfer
            ST_HOLD: state_q <= ST_HOLD;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   assign done_o = enable_i && ((state_q == ST_ENDED && read_out_i) ||
      (state_q == ST_IDLE && rx_zlp_empty_i));

   a_zlp_parks: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (enable_i && state_q == ST_IDLE && rx_zlp_empty_i && !clear_i) |=> state_q == ST_HOLD)
      else $error("zero-length packet did not park tracker");
endmodule : pipe_read_complete
`default_nettype wire

// ==== design/usb_pipe_buffer_ready_irq.sv ====
`timescale 1ns/1ps
`default_nettype none
module usb_pipe_buffer_ready_irq
#(
   parameter int NUM_PIPES = pipe_ready_pkg::NUM_PIPES
)
(
   input wire logic clock_i,
   input wire logic reset_n_i,
   input wire logic status_linking_select_i,
   input wire logic global_ready_irq_enable_i,
   input wire logic func_mode_i,
   input wire logic status_stage_i,
   input wire logic [NUM_PIPES-1:0] read_complete_select_i,
   input wire logic [NUM_PIPES-1:0] pipe_ready_irq_enable_i,
   input wire logic [NUM_PIPES-1:0] dir_tx_i,
   input wire logic [NUM_PIPES-1:0] buffer_access_ready_i,
   input wire logic [NUM_PIPES-1:0] tx_done_i,
   input wire logic [NUM_PIPES-1:0] rx_done_i,
   input wire logic [NUM_PIPES-1:0] rx_toggle_bad_i,
   input wire logic [NUM_PIPES-1:0] rx_short_i,
   input wire logic [NUM_PIPES-1:0] rx_count_end_i,
   input wire logic [NUM_PIPES-1:0] rx_zlp_empty_i,
   input wire logic [NUM_PIPES-1:0] read_out_i,
   input wire logic [NUM_PIPES-1:0] cpu_side_done_i,
   input wire logic [NUM_PIPES-1:0] other_buf_ok_i,
   input wire logic [NUM_PIPES-1:0] pipe_auto_clear_wr_i,
   input wire logic [NUM_PIPES-1:0] buffer_clear_bit_wr_i,
   input wire logic status_wr_i,
   input wire logic [NUM_PIPES-1:0] status_wdata_i,
   output logic [NUM_PIPES-1:0] pipe_ready_flag_o,
   output logic buffer_ready_summary_o,
   output logic irq_o
);
   logic [NUM_PIPES-1:0] flag_q;
   logic [NUM_PIPES-1:0] flag_d;
   logic [NUM_PIPES-1:0] zlp_hold_q;
   logic [NUM_PIPES-1:0] port_trig;
   logic [NUM_PIPES-1:0] done_trig;
   logic [NUM_PIPES-1:0] linked_level;
   logic summary_q;
   logic summary_d;
   logic irq_q;
   logic irq_d;

   // Mode of one pipe from the global linking bit and its read-complete bit
   function automatic logic [1:0] pipe_mode(input logic linked, input logic rdone);
      pipe_mode = {linked, rdone};
   endfunction : pipe_mode

   // Per-pipe event detection
   genvar g;
   generate
      for (g = 0; g < NUM_PIPES; g++)
      begin : gen_pipe
         pipe_ready_trigger u_trig
         (
            .clock_i(clock_i),
            .reset_n_i(reset_n_i),
            .is_ctrl_pipe_i(g == pipe_ready_pkg::CTRL_PIPE_IDX),
            .dir_tx_i(dir_tx_i[g]),
            .func_mode_i(func_mode_i),
            .status_stage_i(status_stage_i),
            .buf_ready_i(buffer_access_ready_i[g]),
            .tx_done_i(tx_done_i[g]),
            .rx_done_i(rx_done_i[g]),
            .rx_toggle_bad_i(rx_toggle_bad_i[g]),
            .cpu_side_done_i(cpu_side_done_i[g]),
            .other_buf_ok_i(other_buf_ok_i[g]),
            .auto_clear_wr_i(pipe_auto_clear_wr_i[g]),
            .trigger_o(port_trig[g])
         );
         // Read-complete tracking; transmit pipes never flag in this mode
         pipe_read_complete u_done
         (
            .clock_i(clock_i),
            .reset_n_i(reset_n_i),
            .enable_i(pipe_mode(status_linking_select_i, read_complete_select_i[g])
               == pipe_ready_pkg::MODE_READ_DONE && !dir_tx_i[g]),
            .rx_short_i(rx_short_i[g]),
            .rx_count_end_i(rx_count_end_i[g]),
            .rx_zlp_empty_i(rx_zlp_empty_i[g]),
            .read_out_i(read_out_i[g]),
            .clear_i(buffer_clear_bit_wr_i[g] || pipe_auto_clear_wr_i[g]),
            .done_o(done_trig[g])
         );
      end
   endgenerate

   // Linked-mode zero-length packet latch, cleared only by buffer clear
   always_ff @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         zlp_hold_q <= '0;
      else
         zlp_hold_q <= (zlp_hold_q | rx_zlp_empty_i) & ~buffer_clear_bit_wr_i;
   end

   // Linked level: buffer status, except control pipe in transmit
   always_comb
   begin
      linked_level = buffer_access_ready_i | zlp_hold_q;
      if (dir_tx_i[pipe_ready_pkg::CTRL_PIPE_IDX])
         linked_level[pipe_ready_pkg::CTRL_PIPE_IDX] = 1'b0;
   end

   // Next flag value per mode; a set arriving with a clear wins
   always_comb
   begin
      flag_d = flag_q;
      for (int i = 0; i < NUM_PIPES; i++)
      begin
         unique case (pipe_mode(status_linking_select_i, read_complete_select_i[i]))
            pipe_ready_pkg::MODE_PORT:
            begin
               if (status_wr_i && !status_wdata_i[i])
                  flag_d[i] = 1'b0;
               if (port_trig[i])
                  flag_d[i] = 1'b1;
            end
            pipe_ready_pkg::MODE_READ_DONE:
            begin
               if (status_wr_i && !status_wdata_i[i])
                  flag_d[i] = 1'b0;
               if (done_trig[i])
                  flag_d[i] = 1'b1;
            end
            // Software writes have no effect while linked
            default: flag_d[i] = linked_level[i];
         endcase
      end
   end

   // Status flag storage
   always_ff @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         flag_q <= {NUM_PIPES{pipe_ready_pkg::FLAG_RESET}};
      else
         flag_q <= flag_d;
   end

   // Summary follows enabled flags; clearing depends on linking mode
   always_comb
   begin
      summary_d = summary_q;
      if (|(flag_d & pipe_ready_irq_enable_i))
         summary_d = 1'b1;
      else if (status_linking_select_i ? (buffer_access_ready_i == '0 && zlp_hold_q == '0)
                                       : (flag_d == '0))
         summary_d = 1'b0;
      irq_d = summary_d && global_ready_irq_enable_i;
   end

   // Summary and interrupt registers
   always_ff @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         summary_q <= pipe_ready_pkg::SUMMARY_RESET;
         irq_q <= 1'b0;
      end
      else
      begin
         summary_q <= summary_d;
         irq_q <= irq_d;
      end
   end

   assign pipe_ready_flag_o = flag_q;
   assign buffer_ready_summary_o = summary_q;
   assign irq_o = irq_q;

   // Assertions
   sequence s_port_trig(int k);
      !status_linking_select_i && !read_complete_select_i[k] && port_trig[k];
   endsequence

   a_trig_sets_flag: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      s_port_trig(1) |=> pipe_ready_flag_o[1])
      else $error("trigger did not set flag");
   a_irq_needs_enable: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      irq_o |-> $past(global_ready_irq_enable_i))
      else $error("interrupt without global enable");
   a_zero_clears: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (!status_linking_select_i && !read_complete_select_i[2] && status_wr_i
       && !status_wdata_i[2] && !port_trig[2]) |=> !pipe_ready_flag_o[2])
      else $error("write of zero did not clear flag");
   a_one_keeps: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (!status_linking_select_i && status_wr_i && status_wdata_i[3] && flag_q[3])
      |=> pipe_ready_flag_o[3])
      else $error("write of one changed flag");
   a_linked_tracks: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (status_linking_select_i && !dir_tx_i[7]) |=> pipe_ready_flag_o[7] == $past(linked_level[7]))
      else $error("linked flag does not track buffer");
   a_ctrl_linked_off: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (status_linking_select_i && dir_tx_i[0]) |=> !pipe_ready_flag_o[0])
      else $error("control pipe transmit flag in linked mode");
   a_summary_clear: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (!status_linking_select_i && flag_d == '0) |=> !buffer_ready_summary_o)
      else $error("summary not cleared");
   a_rdone_tx_quiet: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (!status_linking_select_i && read_complete_select_i[2] && dir_tx_i[2] && !flag_q[2])
      |=> !pipe_ready_flag_o[2])
      else $error("transmit pipe flagged in read-complete mode");

   // Mode of one pipe as the flag logic sees it
   sequence s_in_port(int k);
      !status_linking_select_i && !read_complete_select_i[k];
   endsequence

   sequence s_in_rdone(int k);
      !status_linking_select_i && read_complete_select_i[k];
   endsequence

   // Per-pipe checks; every pipe is covered, not just the sampled ones
   generate
      for (genvar k = 0; k < NUM_PIPES; k++)
      begin : gen_chk
         // A port trigger always lands, even against a clear
         a_port_sets: assert property (@(posedge clock_i) disable iff (!reset_n_i)
            s_in_port(k) ##0 port_trig[k] |=> pipe_ready_flag_o[k])
            else $error("port trigger lost");

         // Without a clear the flag must stay up
         a_port_holds: assert property (@(posedge clock_i) disable iff (!reset_n_i)
            s_in_port(k) ##0 (flag_q[k] && !(status_wr_i && !status_wdata_i[k]))
            |=> pipe_ready_flag_o[k])
            else $error("port flag dropped");

         // No flag may appear without a trigger
         a_port_no_spont: assert property (@(posedge clock_i) disable iff (!reset_n_i)
            s_in_port(k) ##0 (!port_trig[k] && !flag_q[k]) |=> !pipe_ready_flag_o[k])
            else $error("port flag without trigger");

         // Full read-out of a transfer raises the flag
         a_rdone_sets: assert property (@(posedge clock_i) disable iff (!reset_n_i)
            s_in_rdone(k) ##0 done_trig[k] |=> pipe_ready_flag_o[k])
            else $error("read-out did not flag");

         // Nothing else raises it in read-complete mode
         a_rdone_quiet: assert property (@(posedge clock_i) disable iff (!reset_n_i)
            s_in_rdone(k) ##0 (!done_trig[k] && !flag_q[k]) |=> !pipe_ready_flag_o[k])
            else $error("read-complete flag without read-out");

         // Linked flags follow the buffer level one edge later
         a_linked_level: assert property (@(posedge clock_i) disable iff (!reset_n_i)
            status_linking_select_i |=> pipe_ready_flag_o[k] == $past(linked_level[k]))
            else $error("linked flag off level");

         // Software cannot knock a linked flag down
         a_linked_no_clear: assert property (@(posedge clock_i) disable iff (!reset_n_i)
            (status_linking_select_i && status_wr_i && linked_level[k]) |=> pipe_ready_flag_o[k])
            else $error("linked flag cleared by write");

         // An empty-buffer ZLP is latched
         a_zlp_latch: assert property (@(posedge clock_i) disable iff (!reset_n_i)
            (rx_zlp_empty_i[k] && !buffer_clear_bit_wr_i[k]) |=> zlp_hold_q[k])
            else $error("zero-length packet not latched");

         // Only a buffer clear lets it go
         a_zlp_release: assert property (@(posedge clock_i) disable iff (!reset_n_i)
            buffer_clear_bit_wr_i[k] |=> !zlp_hold_q[k])
            else $error("zero-length packet latch stuck");
      end
   endgenerate

   // The interrupt is the summary gated by the global enable
   a_irq_follows: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      1'b1 |=> irq_o == (buffer_ready_summary_o && $past(global_ready_irq_enable_i)))
      else $error("interrupt not summary and enable");

   // Any enabled flag raises the summary
   a_summary_sets: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      |(flag_d & pipe_ready_irq_enable_i) |=> buffer_ready_summary_o)
      else $error("summary not raised");

   // The summary never rises without an enabled flag behind it
   a_summary_cause: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      $rose(buffer_ready_summary_o) |-> $past(|(flag_d & pipe_ready_irq_enable_i)))
      else $error("summary raised without cause");

   // Linked mode drops the summary once every buffer is idle
   a_linked_sum_clear: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (status_linking_select_i && buffer_access_ready_i == '0 && zlp_hold_q == '0
       && !(|(flag_d & pipe_ready_irq_enable_i))) |=> !buffer_ready_summary_o)
      else $error("linked summary not cleared");

   // Control pipe transmit never reaches the flag logic
   a_ctrl_no_trig: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      dir_tx_i[pipe_ready_pkg::CTRL_PIPE_IDX] |-> !port_trig[pipe_ready_pkg::CTRL_PIPE_IDX])
      else $error("control pipe transmit trigger");

   // The status stage silences the port trigger of every pipe at once
   a_stage_all_quiet: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (func_mode_i && status_stage_i) |-> port_trig == '0)
      else $error("trigger during status stage");
endmodule : usb_pipe_buffer_ready_irq
`default_nettype wire

// ==== tb/fifo_engine_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Behavioural pipe FIFO and transaction engine driving the ready logic
module fifo_engine_model
#(
   parameter int N = pipe_ready_pkg::NUM_PIPES
)
(
   input wire logic clock_i,
   output logic [N-1:0] buffer_access_ready_o,
   output logic [N-1:0] other_buf_ok_o,
   output logic [N-1:0] rx_toggle_bad_o,
   output logic [N-1:0] tx_done_o,
   output logic [N-1:0] rx_done_o,
   output logic [N-1:0] rx_short_o,
   output logic [N-1:0] rx_count_end_o,
   output logic [N-1:0] rx_zlp_empty_o,
   output logic [N-1:0] read_out_o,
   output logic [N-1:0] cpu_side_done_o
);
   logic [N-1:0] ev_q [7];
   // Event pulses: 0 sent, 1 received, 2 short, 3 count end, 4 empty ZLP, 5 read out, 6 CPU side done
   assign tx_done_o = ev_q[0];
   assign rx_done_o = ev_q[1];
   assign rx_short_o = ev_q[2];
   assign rx_count_end_o = ev_q[3];
   assign rx_zlp_empty_o = ev_q[4];
   assign read_out_o = ev_q[5];
   assign cpu_side_done_o = ev_q[6];
   initial
   begin
      foreach (ev_q[i]) ev_q[i] = '0;
      buffer_access_ready_o = '0;
      other_buf_ok_o = '0;
      rx_toggle_bad_o = '1;
   end
   // One-cycle event; the toggle qualifier is junk outside the receive pulse
   task automatic pulse(input int sel, input int p, input logic bad);
      @(posedge clock_i);
      ev_q[sel][p] <= 1'h1;
      rx_toggle_bad_o[p] <= bad;
      @(posedge clock_i);
      ev_q[sel][p] <= 1'h0;
      rx_toggle_bad_o[p] <= ~bad;
      #1;
   endtask : pulse
   // Buffer levels: 0 CPU access ready, 1 other buffer ready
   task automatic level(input int sel, input int p, input logic v);
      @(posedge clock_i);
      if (sel == 0) buffer_access_ready_o[p] <= v;
      else other_buf_ok_o[p] <= v;
      @(posedge clock_i);
      #1;
   endtask : level
endmodule : fifo_engine_model
`default_nettype wire

// ==== tb/usb_pipe_buffer_ready_irq_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module usb_pipe_buffer_ready_irq_tb;
   localparam int N = pipe_ready_pkg::NUM_PIPES;
   logic clock_i = 1'h0;
   logic reset_n_i = 1'h0;
   logic link = 1'h0, gen = 1'h1, func = 1'h0, stage = 1'h0, swr = 1'h0, summ, irq;
   logic [N-1:0] rcs = 10'h000, pen = 10'h3FF, dir = 10'h000, acw = 10'h000, bcw = 10'h000, wd = 10'h000;
   logic [N-1:0] flag, buffer_access_ready, obo, tgb, txd, rxd, shrt, cnte, zlp, rdo, csd;
   int bad_count = 0;
   int samples_checked = 0;
   // Free-running 40 MHz clock
   always #12.5 clock_i = ~clock_i;
   fifo_engine_model #(.N(N)) i_fifo (.clock_i(clock_i), .buffer_access_ready_o(buffer_access_ready), .other_buf_ok_o(obo),
      .rx_toggle_bad_o(tgb), .tx_done_o(txd), .rx_done_o(rxd), .rx_short_o(shrt), .rx_count_end_o(cnte),
      .rx_zlp_empty_o(zlp), .read_out_o(rdo), .cpu_side_done_o(csd));
   usb_pipe_buffer_ready_irq #(.NUM_PIPES(N)) i_dut (.clock_i(clock_i), .reset_n_i(reset_n_i),
      .status_linking_select_i(link), .global_ready_irq_enable_i(gen), .func_mode_i(func),
      .status_stage_i(stage), .read_complete_select_i(rcs), .pipe_ready_irq_enable_i(pen), .dir_tx_i(dir),
      .buffer_access_ready_i(buffer_access_ready), .tx_done_i(txd), .rx_done_i(rxd), .rx_toggle_bad_i(tgb), .rx_short_i(shrt),
      .rx_count_end_i(cnte), .rx_zlp_empty_i(zlp), .read_out_i(rdo), .cpu_side_done_i(csd),
      .other_buf_ok_i(obo), .pipe_auto_clear_wr_i(acw), .buffer_clear_bit_wr_i(bcw), .status_wr_i(swr),
      .status_wdata_i(wd), .pipe_ready_flag_o(flag), .buffer_ready_summary_o(summ), .irq_o(irq));
   task automatic check(input string what, input logic [N-1:0] seen, input logic [N-1:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Software status write; a 1 in wd leaves that pipe alone
   task automatic wr_status(input logic [N-1:0] d);
      @(posedge clock_i);
      swr <= 1'h1;
      wd <= d;
      @(posedge clock_i);
      swr <= 1'h0;
      #1;
   endtask : wr_status
   // Software write of 1 to buffer clear (clr) or auto clear
   task automatic sw_pulse(input logic clr, input int p);
      @(posedge clock_i);
      if (clr) bcw[p] <= 1'h1;
      else acw[p] <= 1'h1;
      @(posedge clock_i);
      bcw <= 10'h000;
      acw <= 10'h000;
      #1;
   endtask : sw_pulse
   task automatic sc_port_dir();
      @(posedge clock_i);
      dir <= 10'h007;
      @(posedge clock_i);
      #1;
      check("dir flags", flag, 10'h006);
      check("sum irq", N'({summ, irq}), 10'h003);
      @(posedge clock_i);
      gen <= 1'h0;
      @(posedge clock_i);
      #1;
      check("irq gated", N'({summ, irq}), 10'h002);
      gen <= 1'h1;
      wr_status(10'h3FD);
      check("clear one", flag, 10'h004);
      check("sum kept", N'(summ), 10'h001);
      wr_status(10'h3FB);
      check("sum clear", N'({summ, irq}), 10'h000);
   endtask : sc_port_dir
   task automatic sc_port_events();
      i_fifo.pulse(0, 2, 1'h0);
      i_fifo.pulse(0, 0, 1'h0);
      check("tx done", flag, 10'h004);
      i_fifo.pulse(1, 3, 1'h1);
      check("bad toggle", flag, 10'h004);
      i_fifo.pulse(1, 3, 1'h0);
      check("rx done", flag, 10'h00C);
      wr_status(10'h3FF);
      check("ones keep", flag, 10'h00C);
      func <= 1'h1;
      stage <= 1'h1;
      i_fifo.pulse(1, 4, 1'h0);
      check("status stage", flag, 10'h00C);
      stage <= 1'h0;
      sw_pulse(1'h0, 1);
      check("auto clear", flag, 10'h00E);
      i_fifo.level(1, 5, 1'h1);
      i_fifo.pulse(6, 5, 1'h0);
      check("dbl rx", flag, 10'h02E);
      wr_status(10'h000); // Cleared before the buffer is touched again
      i_fifo.level(1, 2, 1'h1);
      i_fifo.pulse(6, 2, 1'h0);
      check("dbl tx", flag, 10'h004);
      wr_status(10'h000);
   endtask : sc_port_events
   task automatic sc_read_done();
      @(posedge clock_i);
      rcs <= 10'h024;
      i_fifo.pulse(2, 5, 1'h0);
      check("not read", flag, 10'h000);
      i_fifo.pulse(5, 5, 1'h0);
      check("short read", flag, 10'h020);
      wr_status(10'h000);
      sw_pulse(1'h1, 5); // Start next transfer from a clean buffer
      i_fifo.pulse(3, 5, 1'h0);
      i_fifo.pulse(5, 5, 1'h0);
      i_fifo.pulse(0, 2, 1'h0);
      check("count read", flag, 10'h020);
      wr_status(10'h000);
      @(posedge clock_i);
      rcs <= 10'h000;
   endtask : sc_read_done
   task automatic sc_linked();
      @(posedge clock_i);
      link <= 1'h1; // Read-complete already zero everywhere
      i_fifo.level(0, 7, 1'h1);
      check("rx linked", flag, 10'h080);
      wr_status(10'h000);
      check("no sw clear", flag, 10'h080);
      i_fifo.level(0, 1, 1'h1);
      check("tx linked", flag, 10'h082);
      i_fifo.level(0, 7, 1'h0);
      i_fifo.level(0, 1, 1'h0);
      check("linked off", N'({summ, irq}), 10'h000);
      i_fifo.pulse(4, 7, 1'h0);
      repeat (5) @(posedge clock_i);
      #1;
      check("zlp held", flag, 10'h080);
      check("zlp irq", N'(irq), 10'h001);
      sw_pulse(1'h1, 7);
      // Latch drops one edge after the clear, the flag one edge later
      @(posedge clock_i);
      #1;
      check("zlp clear", flag, 10'h000);
   endtask : sc_linked
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : print_verdict
   // Reset for six cycles, then the scenarios in turn
   initial
   begin
      repeat (6) @(posedge clock_i);
      reset_n_i <= 1'h1;
      sc_port_dir();
      sc_port_events();
      sc_read_done();
      sc_linked();
      print_verdict();
   end
   // Whole run needs under a hundred cycles; cut a hang well beyond that
   initial
   begin
      repeat (4000) @(posedge clock_i);
      bad_count++;
      print_verdict();
   end
endmodule : usb_pipe_buffer_ready_irq_tb
`default_nettype wire
